// File: bnf_params.svh
`ifndef BNF_PARAMS_SVH
`define BNF_PARAMS_SVH

// Register byte offsets.
`define BNF_OFF_CTRL 8'hc0
`define BNF_OFF_STS 8'he0
`define BNF_OFF_MSK 8'he4
`define BNF_OFF_LVL 8'he8

// Control register field positions.
`define BNF_B0_EN 0
`define BNF_B0_SEL_LO 1
`define BNF_B0_SEL_HI 3
`define BNF_B0_CNT_LO 4
`define BNF_B0_CNT_HI 6
`define BNF_B0_INV 7
`define BNF_B1_EN 8
`define BNF_B1_SEL_LO 9
`define BNF_B1_SEL_HI 11
`define BNF_B1_CNT_LO 12
`define BNF_B1_CNT_HI 14
`define BNF_B1_INV 15

// Reset values and implemented control bits.
`define BNF_CTRL_RST 16'h0000
`define BNF_CTRL_MASK 16'hffff
`define BNF_STS_RST 2'h0
`define BNF_MSK_RST 2'h0

// Prescaler width covers the deepest division of 128.
`define BNF_PRE_W 7

`endif

// File: bnf_pkg.sv
package bnf_pkg;

	typedef enum logic [1:0] {
		BNF_RESP_OKAY = 2'h0,
		BNF_RESP_SLVERR = 2'h2
	} bnf_resp_t;

	typedef enum logic [2:0] {
		BNF_REG_NONE = 3'h0,
		BNF_REG_CTRL = 3'h1,
		BNF_REG_STS = 3'h3,
		BNF_REG_MSK = 3'h2,
		BNF_REG_LVL = 3'h6
	} bnf_reg_t;

	typedef logic [2:0] bnf_sel_t;
	typedef logic [2:0] bnf_cnt_t;
	typedef logic [6:0] bnf_pre_t;

	// A filter tick falls when the low sel bits of the free prescaler are all ones.
	function automatic logic bnf_tick(input bnf_pre_t pre, input bnf_sel_t sel);
		logic [7:0] m;
		m = (8'h01 << sel) - 8'h01;
		return &(pre | ~m[6:0]);
	endfunction

endpackage

// File: bnf_chan_if.sv
`timescale 1ns/10ps
interface bnf_chan_if;
	import bnf_pkg::*;
	logic en;
	bnf_sel_t sel;
	bnf_cnt_t cnt;
	logic inv;
	logic pin;
	bnf_pre_t pre;
	logic level;
	logic edge_p;

	modport ctl (output en, output sel, output cnt, output inv, output pin, output pre, input level, input edge_p);
	modport flt (input en, input sel, input cnt, input inv, input pin, input pre, output level, output edge_p);
endinterface

// File: bnf_filter_chan.sv
`timescale 1ns/10ps
`include "bnf_params.svh"
module bnf_filter_chan
	import bnf_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Channel settings and results
	bnf_chan_if.flt ch
);
	logic adj;
	logic tick;
	logic level_r;
	logic level_nxt;
	logic edge_r;
	bnf_cnt_t cnt_r;
	bnf_cnt_t cnt_nxt;

	assign adj = ch.pin ^ ch.inv;
	assign tick = bnf_tick(ch.pre, ch.sel);

	always_comb
	begin
		level_nxt = level_r;
		cnt_nxt = cnt_r;
		if (!ch.en)
		begin
			level_nxt = adj;
			cnt_nxt = 3'h0;
		end
		else if (tick)
		begin
			if (adj == level_r)
				cnt_nxt = 3'h0;
			else if (cnt_r == ch.cnt)
			begin
				level_nxt = adj;
				cnt_nxt = 3'h0;
			end
			else
				cnt_nxt = cnt_r + 3'h1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			level_r <= 1'b0;
			cnt_r <= 3'h0;
			edge_r <= 1'b0;
		end
		else
		begin
			level_r <= level_nxt;
			cnt_r <= cnt_nxt;
			edge_r <= level_nxt & ~level_r;
		end
	end

	assign ch.level = level_r;
	assign ch.edge_p = edge_r;

	// Moving a select shifts the tick phase, so each divider check lets go once the select leaves its code.
	sequence s_gap3;
		(!tick || ch.sel != 3'h2)[*3];
	endsequence

	property p_bypass;
		@(posedge aclk) disable iff (!aresetn) !ch.en |=> level_r == $past(adj);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass does not follow pin");

	property p_pol_high;
		@(posedge aclk) disable iff (!aresetn) (!ch.en && !ch.inv && ch.pin) |=> level_r;
	endproperty
	a_pol_high: assert property (p_pol_high) else $error("high pin not detected");

	property p_pol_low;
		@(posedge aclk) disable iff (!aresetn) (!ch.en && ch.inv && !ch.pin) |=> level_r;
	endproperty
	a_pol_low: assert property (p_pol_low) else $error("low pin not detected when inverted");

	property p_undiv;
		@(posedge aclk) disable iff (!aresetn) ch.sel == 3'h0 |-> tick;
	endproperty
	a_undiv: assert property (p_undiv) else $error("undivided clock missing tick");

	property p_div2;
		@(posedge aclk) disable iff (!aresetn)
			(tick && ch.sel == 3'h1) |=> (!tick || ch.sel != 3'h1) ##1 (tick || ch.sel != 3'h1);
	endproperty
	a_div2: assert property (p_div2) else $error("divide by 2 wrong");

	property p_div4;
		@(posedge aclk) disable iff (!aresetn)
			(tick && ch.sel == 3'h2) |=> s_gap3 ##1 (tick || ch.sel != 3'h2);
	endproperty
	a_div4: assert property (p_div4) else $error("divide by 4 wrong");

	property p_div128;
		@(posedge aclk) disable iff (!aresetn)
			(tick && ch.sel == 3'h7) |=> (!tick || ch.sel != 3'h7)[*8];
	endproperty
	a_div128: assert property (p_div128) else $error("divide by 128 ticks too soon");

	property p_count;
		@(posedge aclk) disable iff (!aresetn)
			(ch.en && tick && adj != level_r && cnt_r != ch.cnt) |=> cnt_r == $past(cnt_r) + 3'h1 && $stable(level_r);
	endproperty
	a_count: assert property (p_count) else $error("filter counter did not advance");

	property p_restart;
		@(posedge aclk) disable iff (!aresetn) (ch.en && tick && adj == level_r) |=> cnt_r == 3'h0;
	endproperty
	a_restart: assert property (p_restart) else $error("filter counter not cleared");

	property p_accept;
		@(posedge aclk) disable iff (!aresetn)
			(ch.en && tick && adj != level_r && cnt_r == ch.cnt) |=> level_r == $past(adj) && cnt_r == 3'h0;
	endproperty
	a_accept: assert property (p_accept) else $error("stable input not accepted");

	property p_hold;
		@(posedge aclk) disable iff (!aresetn) (ch.en && !tick) |=> $stable(level_r);
	endproperty
	a_hold: assert property (p_hold) else $error("filtered level changed off tick");
endmodule

// File: bnf_top.sv
// Functional notes
// - Brake 1 clock select codes 010..111 divide bus clock by 4 to 128.
// - Brake 1 codes 000 and 001 give undivided clock and divide by 2.
// - Brake 1 enable bit 8 routes input through filter; clear bypasses it.
// - Brake 0 inverse clear: rising edge or high level is a brake.
// - Brake 0 inverse set: falling edge or low level is a brake.
// - Brake 0 counter counts zero to count field bits 6:4 on filter ticks.
// - Brake 0 select bits 3:1 divide bus clock by two to the code.
// - Brake 1 counter counts zero to count field bits 14:12 on its ticks.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "bnf_params.svh"
module bnf_top
	import bnf_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Brake input pins
	input wire logic brake_input_pin0,
	input wire logic brake_input_pin1,
	// Filtered brake results for the detector
	output logic brake0_level,
	output logic brake1_level,
	output logic brake0_edge,
	output logic brake1_edge,
	// Interrupt
	output logic irq
);
	logic [15:0] ctrl_r;
	logic [1:0] sts_r;
	logic [1:0] msk_r;
	bnf_pre_t pre_r;
	logic wr_go;
	logic rd_go;
	logic bvalid_r;
	logic rvalid_r;
	bnf_resp_t bresp_r;
	bnf_resp_t rresp_r;
	logic [31:0] rdata_r;
	bnf_reg_t wsel;
	bnf_reg_t rsel;
	logic [15:0] wmask;
	logic [1:0] edges;
	logic [1:0] w1c;

	bnf_chan_if ch0();
	bnf_chan_if ch1();

	function automatic bnf_reg_t bnf_decode(input logic [7:0] a);
		if (a == `BNF_OFF_CTRL)
			return BNF_REG_CTRL;
		else if (a == `BNF_OFF_STS)
			return BNF_REG_STS;
		else if (a == `BNF_OFF_MSK)
			return BNF_REG_MSK;
		else if (a == `BNF_OFF_LVL)
			return BNF_REG_LVL;
		else
			return BNF_REG_NONE;
	endfunction

	// One write and one read at a time: a new request waits until the last answer is taken.
	assign wr_go = awvalid & wvalid & ~bvalid_r;
	assign rd_go = arvalid & ~rvalid_r;
	assign awready = wr_go;
	assign wready = wr_go;
	assign arready = rd_go;
	assign wsel = bnf_decode(awaddr);
	assign rsel = bnf_decode(araddr);
	assign wmask = {{8{wstrb[1]}}, {8{wstrb[0]}}};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_r <= `BNF_CTRL_RST;
		else if (wr_go && wsel == BNF_REG_CTRL)
			ctrl_r <= ((ctrl_r & ~wmask) | (wdata[15:0] & wmask)) & `BNF_CTRL_MASK;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			msk_r <= `BNF_MSK_RST;
		else if (wr_go && wsel == BNF_REG_MSK && wstrb[0])
			msk_r <= wdata[1:0];
	end

	// A new event wins over a simultaneous write-one-to-clear.
	assign edges = {ch1.edge_p, ch0.edge_p};
	assign w1c = (wr_go && wsel == BNF_REG_STS && wstrb[0]) ? wdata[1:0] : 2'h0;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sts_r <= `BNF_STS_RST;
		else
			sts_r <= (sts_r & ~w1c) | edges;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pre_r <= '0;
		else
			pre_r <= pre_r + 7'h01;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= BNF_RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_r <= 1'b1;
			bresp_r <= (wsel == BNF_REG_NONE) ? BNF_RESP_SLVERR : BNF_RESP_OKAY;
		end
		else if (bready)
			bvalid_r <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rresp_r <= BNF_RESP_OKAY;
			rdata_r <= 32'h0;
		end
		else if (rd_go)
		begin
			rvalid_r <= 1'b1;
			rresp_r <= BNF_RESP_OKAY;
			rdata_r <= 32'h0;
			if (rsel == BNF_REG_CTRL)
				rdata_r <= {16'h0, ctrl_r};
			else if (rsel == BNF_REG_STS)
				rdata_r <= {30'h0, sts_r};
			else if (rsel == BNF_REG_MSK)
				rdata_r <= {30'h0, msk_r};
			else if (rsel == BNF_REG_LVL)
				rdata_r <= {30'h0, ch1.level, ch0.level};
			else
				rresp_r <= BNF_RESP_SLVERR;
		end
		else if (rready)
			rvalid_r <= 1'b0;
	end

	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign rvalid = rvalid_r;
	assign rresp = rresp_r;
	assign rdata = rdata_r;

	assign ch0.en = ctrl_r[`BNF_B0_EN];
	assign ch0.sel = ctrl_r[`BNF_B0_SEL_HI:`BNF_B0_SEL_LO];
	assign ch0.cnt = ctrl_r[`BNF_B0_CNT_HI:`BNF_B0_CNT_LO];
	assign ch0.inv = ctrl_r[`BNF_B0_INV];
	assign ch0.pin = brake_input_pin0;
	assign ch0.pre = pre_r;
	assign ch1.en = ctrl_r[`BNF_B1_EN];
	assign ch1.sel = ctrl_r[`BNF_B1_SEL_HI:`BNF_B1_SEL_LO];
	assign ch1.cnt = ctrl_r[`BNF_B1_CNT_HI:`BNF_B1_CNT_LO];
	assign ch1.inv = ctrl_r[`BNF_B1_INV];
	assign ch1.pin = brake_input_pin1;
	assign ch1.pre = pre_r;

	bnf_filter_chan u_chan0 (.aclk(aclk), .aresetn(aresetn), .ch(ch0.flt));
	bnf_filter_chan u_chan1 (.aclk(aclk), .aresetn(aresetn), .ch(ch1.flt));

	assign brake0_level = ch0.level;
	assign brake1_level = ch1.level;
	assign brake0_edge = ch0.edge_p;
	assign brake1_edge = ch1.edge_p;
	assign irq = |(sts_r & msk_r);

	property p_ctrl_steers;
		@(posedge aclk) disable iff (!aresetn)
			(wr_go && wsel == BNF_REG_CTRL && wstrb == 4'hf) |=> ctrl_r == $past(wdata[15:0]);
	endproperty
	a_ctrl_steers: assert property (p_ctrl_steers) else $error("control write lost");

	property p_event_sticky;
		@(posedge aclk) disable iff (!aresetn) ch0.edge_p |=> sts_r[0];
	endproperty
	a_event_sticky: assert property (p_event_sticky) else $error("brake 0 event not latched");

	// With a filter off, each level must follow its own pin through its own inverse bit, which catches crossed fields.
	property p_b1_bypass;
		@(posedge aclk) disable iff (!aresetn)
			!ctrl_r[`BNF_B1_EN] |=> brake1_level == $past(brake_input_pin1 ^ ctrl_r[`BNF_B1_INV]);
	endproperty
	a_b1_bypass: assert property (p_b1_bypass) else $error("brake 1 bypass wiring wrong");

	property p_b0_polarity;
		@(posedge aclk) disable iff (!aresetn)
			!ctrl_r[`BNF_B0_EN] |=> brake0_level == $past(brake_input_pin0 ^ ctrl_r[`BNF_B0_INV]);
	endproperty
	a_b0_polarity: assert property (p_b0_polarity) else $error("brake 0 polarity wiring wrong");

	property p_event_sticky1;
		@(posedge aclk) disable iff (!aresetn) ch1.edge_p |=> sts_r[1];
	endproperty
	a_event_sticky1: assert property (p_event_sticky1) else $error("brake 1 event not latched");

	sequence s_clear1;
		wr_go && wsel == BNF_REG_STS && wstrb[0] && wdata[1] && !ch1.edge_p;
	endsequence

	property p_clear1;
		@(posedge aclk) disable iff (!aresetn) s_clear1 |=> !sts_r[1];
	endproperty
	a_clear1: assert property (p_clear1) else $error("brake 1 status not cleared");
endmodule

// File: bnf_pin_model.sv
`timescale 1ns/10ps
// Two external brake pins, moved just after a clock edge because the block takes them as synchronous.
module bnf_pin_model (
	// Clock
	input wire logic aclk,
	// Pins
	output logic [1:0] pin
);
	initial pin = 2'h0;
	task automatic drive(input int ch, input logic v);
		@(posedge aclk);
		if (ch == 0)
			pin[0] <= v;
		else
			pin[1] <= v;
	endtask
endmodule

// File: test_brake_input_noise_filter.sv
`timescale 1ns/10ps
`include "bnf_params.svh"
module test_brake_input_noise_filter;
	import bnf_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bvalid, arvalid, rvalid, awready, wready, arready, irq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, x;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, pin, lvl, edg;
	int mismatches, check_count, ch, s;
	logic [33:0] q[$];
	bnf_pin_model i_pin (.aclk(aclk), .pin(pin));
	bnf_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(1'b1), .brake_input_pin0(pin[0]), .brake_input_pin1(pin[1]),
		.brake0_level(lvl[0]), .brake1_level(lvl[1]), .brake0_edge(edg[0]), .brake1_edge(edg[1]), .irq(irq));
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] v);
		check_count++;
		if (e !== v)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, v);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Bounded wait on one handshake: 0 write taken, 1 write answer, 2 read taken, 3 read answer.
	task automatic wt(input int w);
		int k;
		logic [3:0] v;
		for (k = 0; k < 50; k++)
		begin
			@(posedge aclk);
			v = {rvalid, arready, bvalid, awready && wready};
			if (v[w])
				break;
		end
		if (k == 50)
		begin
			mismatches++;
			give_verdict();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		wt(0);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		wt(1);
		chk("bresp", e, bresp);
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		q.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		wt(2);
		arvalid <= 1'b0;
		wt(3);
	endtask
	always @(posedge aclk)
		if (aresetn && rvalid && q.size() > 0)
			chk("read", q.pop_front(), {rresp, rdata});
	// A pulse of c filter periods must be swallowed; a steady change passes after c+1 ticks.
	task automatic flt(input int ch, input int s, input int c);
		int k;
		logic seen;
		wr(`BNF_OFF_CTRL, 32'(1 | s << 1 | c << 4) << (8 * ch), 2'h0);
		repeat (((c + 2) << s) + 4) @(posedge aclk);
		if (c > 0)
		begin
			i_pin.drive(ch, 1'b1);
			repeat ((c << s) - 1) @(posedge aclk);
			i_pin.drive(ch, 1'b0);
		end
		seen = 1'b0;
		repeat (((c + 2) << s) + 4) @(posedge aclk) seen |= lvl[ch];
		chk("glitch", 0, seen);
		i_pin.drive(ch, 1'b1);
		k = 0;
		while (!lvl[ch] && k < 1200)
		begin
			@(posedge aclk);
			k++;
		end
		if (k == 1200)
		begin
			mismatches++;
			give_verdict();
		end
		// The first tick comes 1 to 2**s edges after the pin moves; the level shows one edge after tick c+1.
		chk("delay", 1, k >= (c << s) + 2 && k <= ((c + 1) << s) + 1);
		chk("edge", 1, edg[ch]);
		@(posedge aclk);
		chk("edge_len", 0, edg[ch]);
		i_pin.drive(ch, 1'b0);
		repeat (((c + 2) << s) + 4) @(posedge aclk);
		chk("fall", 0, lvl[ch]);
	endtask
	initial
	begin
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		arvalid = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		mismatches = 0;
		check_count = 0;
		void'($urandom(32'h63de));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`BNF_OFF_CTRL, 34'h0);
		x = $urandom();
		wr(`BNF_OFF_CTRL, x, 2'h0);
		rd(`BNF_OFF_CTRL, {18'h0, x[15:0]});
		wr(8'h10, x, 2'h2);
		rd(8'h10, 34'h200000000);
		for (ch = 0; ch < 2; ch++)
			for (s = 0; s < 8; s++)
				flt(ch, s, $urandom_range(7, 0));
		// Bypassed filter: the inverted pin shows one cycle later.
		for (ch = 0; ch < 2; ch++)
		begin
			wr(`BNF_OFF_CTRL, 32'h80 << (8 * ch), 2'h0);
			@(posedge aclk);
			chk("inv_low", 1, lvl[ch]);
			i_pin.drive(ch, 1'b1);
			repeat (2) @(posedge aclk);
			chk("inv_high", 0, lvl[ch]);
			wr(`BNF_OFF_CTRL, 32'h0, 2'h0);
			@(posedge aclk);
			chk("plain_high", 1, lvl[ch]);
			i_pin.drive(ch, 1'b0);
		end
		repeat (4) @(posedge aclk);
		rd(`BNF_OFF_STS, 34'h3);
		rd(`BNF_OFF_LVL, 34'h0);
		chk("irq_masked", 0, irq);
		wr(`BNF_OFF_MSK, 32'h2, 2'h0);
		chk("irq_on", 1, irq);
		wr(`BNF_OFF_STS, 32'h2, 2'h0);
		chk("irq_off", 0, irq);
		rd(`BNF_OFF_STS, 34'h1);
		rd(`BNF_OFF_MSK, 34'h2);
		give_verdict();
	end
endmodule
